// >>> watchdog_params.svh
`ifndef WATCHDOG_PARAMS_SVH
`define WATCHDOG_PARAMS_SVH

// register offsets (byte addresses)
`define OFS_CLEAR_KEY      16'hF00E
`define OFS_PERIOD_MODE    16'hF00F
`define OFS_IRQ_STATUS     16'hF010
`define OFS_IRQ_CLEAR      16'hF011
`define OFS_IRQ_ENABLE     16'hF012

// reset values
`define RST_CLEAR_KEY      8'h00
`define RST_PERIOD_MODE    2'h2
`define RST_IRQ_ENABLE     2'h3

// clear key bytes
`define KEY_FIRST          8'h5A
`define KEY_SECOND         8'hA5

// field positions
`define POINTER_BIT        0
`define PERIOD_LSB         0
`define PERIOD_MSB         1
`define EVT_FIRST_OVF      0
`define EVT_SECOND_OVF     1

// overflow periods in milliseconds
`define PERIOD_125_MS      125
`define PERIOD_500_MS      500
`define PERIOD_2S_MS       2000
`define PERIOD_8S_MS       8000

// clock rate
`define CLK_HZ             20000000

`endif

// >>> watchdog_pkg.sv
`default_nettype none
package watchdog_pkg;
	typedef logic [15:0] addr_t;
	typedef logic [7:0]  byte_t;
	typedef logic [1:0]  period_sel_t;
	typedef enum logic [1:0] {
		SEL_125MS,
		SEL_500MS,
		SEL_2S,
		SEL_8S
	} period_code_t;
	typedef enum {
		WAIT_OSC,
		ARMED,
		NMI_SENT
	} wdt_state_t;
endpackage
`default_nettype wire

// >>> free_running_watchdog.sv
// The strobed register port was chosen for this implementation.
`include "watchdog_params.svh"
`default_nettype none
module free_running_watchdog #(
	parameter longint MS_125_CYCLES =
		longint'(`CLK_HZ) / 1000 * `PERIOD_125_MS,
	parameter longint MS_500_CYCLES =
		longint'(`CLK_HZ) / 1000 * `PERIOD_500_MS,
	parameter longint S2_CYCLES =
		longint'(`CLK_HZ) / 1000 * `PERIOD_2S_MS,
	parameter longint S8_CYCLES =
		longint'(`CLK_HZ) / 1000 * `PERIOD_8S_MS,
	parameter int     COUNT_W = 28
) (
	// clock and reset
	input  wire logic                 CLK,
	input  wire logic                 RST_N,
	input  wire logic                 CE,
	// register port
	input  wire watchdog_pkg::addr_t  ADDR,
	input  wire watchdog_pkg::byte_t  WDATA,
	input  wire logic                 WR,
	input  wire logic                 RD,
	output var  watchdog_pkg::byte_t  RDATA,
	// chip state
	input  wire logic                 LOW_SPEED_CLOCK_READY,
	input  wire logic                 STOP_MODE,
	input  wire logic                 HALT_MODE,
	// outputs
	output var  logic                 WATCHDOG_NMI_REQUEST,
	output var  logic                 HALT_RELEASE,
	output var  logic                 WATCHDOG_RESET,
	output var  logic                 IRQ
);
	import watchdog_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// a period of zero cycles never reaches its terminal count, and a
	// counter narrower than a period would wrap without overflowing
	if (COUNT_W < 2 || COUNT_W > 62) begin : g_bad_width
		$error("COUNT_W out of range");
	end
	if (MS_125_CYCLES < 1) begin : g_bad_125
		$error("shortest period must be at least one cycle");
	end
	if (MS_500_CYCLES < 1) begin : g_bad_500
		$error("second period must be at least one cycle");
	end
	if (S2_CYCLES < 1) begin : g_bad_2s
		$error("third period must be at least one cycle");
	end
	if (S8_CYCLES < 1) begin : g_bad_8s
		$error("longest period must be at least one cycle");
	end
	if (MS_125_CYCLES > (longint'(1) << COUNT_W) ||
	    MS_500_CYCLES > (longint'(1) << COUNT_W) ||
	    S2_CYCLES > (longint'(1) << COUNT_W) ||
	    S8_CYCLES > (longint'(1) << COUNT_W)) begin : g_narrow
		$error("COUNT_W too narrow for a period");
	end

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic osc_meta, osc_ready;
	logic stop_meta, stop_sync;

	// the oscillator flag arrives from another clock; only osc_ready
	// is read by the logic
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			osc_meta  <= 1'b0;
			osc_ready <= 1'b0;
		end else if (CE) begin
			osc_meta  <= LOW_SPEED_CLOCK_READY;
			osc_ready <= osc_meta;
		end
	end

	// stop comes from the power controller, off this clock
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			stop_meta <= 1'b0;
			stop_sync <= 1'b0;
		end else if (CE) begin
			stop_meta <= STOP_MODE;
			stop_sync <= stop_meta;
		end
	end

	// ------------------------------------------------------------
	// state and decode
	// ------------------------------------------------------------
	wdt_state_t          state;
	logic                pointer;
	logic                first_ok;
	period_sel_t         period_sel;
	logic [COUNT_W-1:0]  count;
	logic [COUNT_W-1:0]  limit;
	logic                running;
	logic                overflow;
	logic                wr_key, wr_mode, wr_iclr, wr_ien;
	logic                key_taken;
	logic                valid_clear;
	logic [1:0]          irq_status, irq_enable, events;
	logic                first_ovf, second_ovf;
	logic [COUNT_W-1:0]  next_count;
	wdt_state_t          next_state;
	byte_t               next_rdata;

	// ------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------
	// stop mode suspends the counter and the clear key; oscillator gate covers reset and
	// stop exit since the oscillator restarts after stop
	assign running  = osc_ready && !stop_sync;
	assign wr_key   = WR && ADDR == `OFS_CLEAR_KEY;
	assign wr_mode  = WR && ADDR == `OFS_PERIOD_MODE;
	assign wr_iclr  = WR && ADDR == `OFS_IRQ_CLEAR;
	assign wr_ien   = WR && ADDR == `OFS_IRQ_ENABLE;
	assign key_taken = wr_key && running;

	// ------------------------------------------------------------
	// period selection
	// ------------------------------------------------------------
	// counting 0 to limit inclusive gives a period of exactly N cycles
	always_comb begin
		unique case (period_code_t'(period_sel))
			SEL_125MS: limit = COUNT_W'(MS_125_CYCLES - 1);
			SEL_500MS: limit = COUNT_W'(MS_500_CYCLES - 1);
			SEL_2S:    limit = COUNT_W'(S2_CYCLES - 1);
			SEL_8S:    limit = COUNT_W'(S8_CYCLES - 1);
		endcase
	end

	// ------------------------------------------------------------
	// clear detection
	// ------------------------------------------------------------
	// second byte accepted only after a matching first byte
	assign valid_clear = key_taken && pointer && first_ok &&
	                     WDATA == `KEY_SECOND;
	assign overflow = running && !valid_clear &&
	                  count >= limit;

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	// no software path stops it; only stop mode or oscillator loss
	// a valid clear or an overflow restarts the period from zero
	always_comb begin
		if (valid_clear || overflow)
			next_count = '0;
		else
			next_count = count + 1'b1;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			count <= '0;
		else if (CE && running)
			count <= next_count;
	end

	// ------------------------------------------------------------
	// clear sequence pointer
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			pointer <= 1'b0;
		else if (CE) begin
			if (overflow)
				pointer <= 1'b0;
			else if (key_taken)
				pointer <= ~pointer;
		end
	end

	// remembers whether the byte taken at pointer 0 was the first key;
	// a wrong first byte keeps this low so the next second key cannot
	// clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			first_ok <= 1'b0;
		else if (CE) begin
			if (overflow)
				first_ok <= 1'b0;
			else if (key_taken)
				first_ok <= !pointer && WDATA == `KEY_FIRST;
		end
	end

	// ------------------------------------------------------------
	// overflow sequencing
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		unique case (state)
			WAIT_OSC:
				if (osc_ready)
					next_state = ARMED;
			ARMED:
				if (overflow)
					next_state = NMI_SENT;
			NMI_SENT:
				if (valid_clear)
					next_state = ARMED;
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			state <= WAIT_OSC;
		else if (CE)
			state <= next_state;
	end

	// the first overflow after arming or after a valid clear only
	// interrupts; software gets one more period before the reset
	assign first_ovf  = overflow && state != NMI_SENT;
	assign second_ovf = overflow && state == NMI_SENT;

	// ------------------------------------------------------------
	// overflow outputs
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			WATCHDOG_NMI_REQUEST <= 1'b0;
		else if (CE)
			WATCHDOG_NMI_REQUEST <= first_ovf;
	end

	// only a sleeping core needs waking, so the pulse is gated by halt
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			HALT_RELEASE <= 1'b0;
		else if (CE)
			HALT_RELEASE <= first_ovf && HALT_MODE;
	end

	// held until system reset clears the block
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			WATCHDOG_RESET <= 1'b0;
		else if (CE && second_ovf)
			WATCHDOG_RESET <= 1'b1;
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			period_sel <= `RST_PERIOD_MODE;
		else if (CE && wr_mode)
			period_sel <= WDATA[`PERIOD_MSB:`PERIOD_LSB];
	end

	// ------------------------------------------------------------
	// interrupt registers
	// ------------------------------------------------------------
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			irq_enable <= `RST_IRQ_ENABLE;
		else if (CE && wr_ien)
			irq_enable <= WDATA[1:0];
	end

	assign events = {second_ovf, first_ovf};

	// a new event wins over a clear in the same cycle, so an overflow
	// is never lost to software clearing the previous one
	for (genvar b = 0; b < $bits(irq_status); b++) begin : g_status
		logic clear_bit;
		assign clear_bit = wr_iclr && WDATA[b];
		always_ff @(posedge CLK or negedge RST_N) begin
			if (!RST_N)
				irq_status[b] <= 1'b0;
			else if (CE) begin
				if (events[b])
					irq_status[b] <= 1'b1;
				else if (clear_bit)
					irq_status[b] <= 1'b0;
			end
		end
	end

	assign IRQ = |(irq_status & irq_enable);

	// ------------------------------------------------------------
	// read port
	// ------------------------------------------------------------
	// read data stand one cycle after the strobe and are zero
	// otherwise, so a stale value is never taken for a new read
	always_comb begin
		next_rdata = 8'h00;
		if (RD) begin
			unique case (ADDR)
				`OFS_CLEAR_KEY:
					next_rdata = {7'h00, pointer};
				`OFS_PERIOD_MODE:
					next_rdata = {6'h00, period_sel};
				`OFS_IRQ_STATUS:
					next_rdata = {6'h00, irq_status};
				`OFS_IRQ_ENABLE:
					next_rdata = {6'h00, irq_enable};
				default:
					next_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N)
			RDATA <= `RST_CLEAR_KEY;
		else if (CE)
			RDATA <= next_rdata;
	end

endmodule // free_running_watchdog
`default_nettype wire

// >>> free_running_watchdog_monitor.sv
`default_nettype none
module free_running_watchdog_monitor (
	// clock and reset
	input wire logic                CLK,
	input wire logic                RST_N,
	// register read side
	input wire watchdog_pkg::addr_t ADDR,
	input wire logic                RD,
	input wire watchdog_pkg::byte_t RDATA,
	// chip state and events
	input wire logic                LOW_SPEED_CLOCK_READY,
	input wire logic                STOP_MODE,
	input wire logic                WATCHDOG_NMI_REQUEST,
	input wire logic                HALT_RELEASE,
	input wire logic                WATCHDOG_RESET
);
	import watchdog_pkg::*;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// six cycles covers the two-flop sync plus the overflow register
	sequence stop_held; STOP_MODE [*6]; endsequence
	sequence osc_down; !LOW_SPEED_CLOCK_READY [*6]; endsequence
	AST_NMI_GAP: assert property (
		WATCHDOG_NMI_REQUEST |=> !WATCHDOG_NMI_REQUEST [*8])
		else $error("nmi gap");
	AST_RESET_HELD: assert property (
		WATCHDOG_RESET |=> WATCHDOG_RESET) else $error("reset drop");
	AST_WAKE: assert property (
		HALT_RELEASE |-> WATCHDOG_NMI_REQUEST) else $error("wake");
	AST_STOP: assert property (
		stop_held |-> !WATCHDOG_NMI_REQUEST && !$rose(WATCHDOG_RESET))
		else $error("ran in stop");
	AST_OSC: assert property (
		osc_down |-> !WATCHDOG_NMI_REQUEST) else $error("ran early");
	AST_IDLE: assert property (
		!RD |=> RDATA == 8'h00) else $error("rdata idle");
	AST_KEY: assert property (
		RD && ADDR == 16'hF00E |=> RDATA[7:1] == 7'h00)
		else $error("key read");
	AST_MODE: assert property (
		RD && ADDR == 16'hF00F |=> RDATA[7:2] == 6'h00)
		else $error("mode read");
endmodule // free_running_watchdog_monitor

bind free_running_watchdog free_running_watchdog_monitor
	free_running_watchdog_monitor_i (.CLK(CLK), .RST_N(RST_N),
	.ADDR(ADDR), .RD(RD), .RDATA(RDATA),
	.LOW_SPEED_CLOCK_READY(LOW_SPEED_CLOCK_READY),
	.STOP_MODE(STOP_MODE), .WATCHDOG_NMI_REQUEST(WATCHDOG_NMI_REQUEST),
	.HALT_RELEASE(HALT_RELEASE), .WATCHDOG_RESET(WATCHDOG_RESET));
`default_nettype wire

// >>> free_running_watchdog_tb.sv
`default_nettype none
module free_running_watchdog_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import watchdog_pkg::*;
	logic  CLK = 0, RST_N = 0, CE = 1, WR = 0, RD = 0, HALT_MODE = 0;
	logic  LOW_SPEED_CLOCK_READY = 0, STOP_MODE = 0;
	addr_t ADDR = '0;
	byte_t WDATA = '0, RDATA;
	logic  WATCHDOG_NMI_REQUEST, HALT_RELEASE, WATCHDOG_RESET, IRQ;
	int    fails = 0, samples_checked = 0;
	always #25 CLK = ~CLK;
	localparam int P125 = 20, P500 = 40, P2S = 80, P8S = 160;
	free_running_watchdog #(.MS_125_CYCLES(P125), .MS_500_CYCLES(P500),
		.S2_CYCLES(P2S), .S8_CYCLES(P8S)) free_running_watchdog_i (
		.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA),
		.LOW_SPEED_CLOCK_READY(LOW_SPEED_CLOCK_READY),
		.STOP_MODE(STOP_MODE), .HALT_MODE(HALT_MODE),
		.WATCHDOG_NMI_REQUEST(WATCHDOG_NMI_REQUEST),
		.HALT_RELEASE(HALT_RELEASE), .WATCHDOG_RESET(WATCHDOG_RESET),
		.IRQ(IRQ));
	// ----
	// bus tasks
	// ----
	task automatic chk(string what, int e, logic [31:0] got);
		samples_checked++;
		if (got !== 32'(e)) begin
			fails++;
			$display("wrong value %s expected %0h seen %0h", what, e, got);
		end
	endtask
	// one cycle of slack either way: the clear lands a cycle after the write
	function automatic logic [31:0] near(int n, int e);
		return 32'(n >= e - 1 && n <= e + 1);
	endfunction
	// period in cycles for each mode code, as set at the instance
	function automatic int period_of(int code);
		case (code)
			0: return P125;
			1: return P500;
			2: return P2S;
			default: return P8S;
		endcase
	endfunction
	task automatic wr(addr_t a, byte_t d);
		@(posedge CLK);
		ADDR  <= a;
		WDATA <= d;
		WR    <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	task automatic rdc(string what, addr_t a, int e);
		@(posedge CLK);
		ADDR <= a;
		RD   <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		chk(what, e, {24'h0, RDATA});
	endtask
	task automatic clr();
		wr(16'hF00E, 8'h5A);
		wr(16'hF00E, 8'hA5);
	endtask
	task automatic wait_nmi(output int n);
		n = 0;
		do begin
			@(negedge CLK);
			n++;
		end while (WATCHDOG_NMI_REQUEST !== 1'b1 && n < 400);
	endtask
	task automatic report_and_stop();
		if (fails == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge CLK);
		fails++;
		report_and_stop();
	end
	initial begin
		int    n;
		byte_t d;
		n = $urandom(32'h857C87D4);
		repeat (3) @(posedge CLK);
		RST_N <= 1'b1;
		rdc("key", 16'hF00E, 0);
		rdc("mode", 16'hF00F, 2);
		rdc("hole", 16'hF020, 0);
		wr(16'hF00E, 8'h5A);
		rdc("ptr", 16'hF00E, 0);
		@(posedge CLK) LOW_SPEED_CLOCK_READY <= 1'b1;
		repeat (4) @(posedge CLK);
		d = byte_t'($urandom);
		wr(16'hF00E, d);
		rdc("ptr", 16'hF00E, 1);
		wr(16'hF00E, ~d);
		rdc("ptr", 16'hF00E, 0);
		for (int i = 0; i < 4; i++) begin
			clr();
			wr(16'hF00F, 8'(i));
			rdc("mode", 16'hF00F, i);
			clr();
			wait_nmi(n);
			chk("period", 1, near(n, period_of(i)));
			chk("rst", 0, 32'(WATCHDOG_RESET));
			rdc("ptr", 16'hF00E, 0);
			chk("irq", 1, 32'(IRQ));
			wr(16'hF011, 8'h03);
			@(negedge CLK);
			chk("irq", 0, 32'(IRQ));
		end
		// a stray first key leaves the pair out of step, so no clear
		clr();
		repeat (50 + $urandom_range(20)) @(posedge CLK);
		wr(16'hF00E, 8'h5A);
		wr(16'hF00E, 8'h5A);
		wr(16'hF00E, 8'hA5);
		rdc("ptr", 16'hF00E, 1);
		wait_nmi(n);
		chk("stray", 1, 32'(n < 140));
		@(posedge CLK) HALT_MODE <= 1'b1;
		clr();
		wr(16'hF012, 8'h00);
		wr(16'hF011, 8'h03);
		wr(16'hF00F, 8'h00);
		wait_nmi(n);
		chk("wake", 1, 32'(HALT_RELEASE));
		chk("mask", 0, 32'(IRQ));
		chk("rst", 0, 32'(WATCHDOG_RESET));
		wr(16'hF012, 8'h01);
		@(negedge CLK);
		chk("irq", 1, 32'(IRQ));
		wr(16'hF011, 8'h01);
		@(negedge CLK);
		chk("irq", 0, 32'(IRQ));
		@(posedge CLK) HALT_MODE <= 1'b0;
		clr();
		@(posedge CLK) STOP_MODE <= 1'b1;
		repeat (4) @(posedge CLK);
		wr(16'hF00E, 8'h5A);
		rdc("ptr", 16'hF00E, 0);
		repeat (200) @(posedge CLK);
		STOP_MODE <= 1'b0;
		wait_nmi(n);
		chk("stop", 1, 32'(n > 10 && n < 30));
		n = 0;
		while (WATCHDOG_RESET !== 1'b1 && n < 60) begin
			@(negedge CLK);
			n++;
		end
		chk("second", 1, near(n, 20));
		@(posedge CLK) CE <= 1'b0;
		wr(16'hF00E, 8'h5A);
		@(posedge CLK) CE <= 1'b1;
		rdc("freeze", 16'hF00E, 0);
		@(posedge CLK) RST_N <= 1'b0;
		@(posedge CLK) RST_N <= 1'b1;
		rdc("mode", 16'hF00F, 2);
		chk("rst", 0, 32'(WATCHDOG_RESET));
		report_and_stop();
	end
endmodule // free_running_watchdog_tb
`default_nettype wire
